/* File: rtl/ptdg_defines.svh */
// constants for the pwm timebase and duty generator
// Function
// - pwm waveform with up to ten-bit duty
// - zero unit control forces pwm latch low
// - period is (limit+1) times 4 times prescale
// - limit match clears counter, sets pin unless duty is zero, loads
// - postscaler never changes the output period
// - duty: upper eight bits plus control 5:4
// - high time is duty times osc times prescale
// - duty writable anytime, shadow loads on match
// - shadow plus 2-bit latch double buffer
// - pin clears when shadow meets extended counter
// - duty beyond period keeps pin high
// - prescale factors of 1, 4 and 16
`ifndef PTDG_DEFINES_SVH
`define PTDG_DEFINES_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define PTDG_ADDR_COUNTER 3'h0
`define PTDG_ADDR_PERIOD 3'h1
`define PTDG_ADDR_TB_CTRL 3'h2
`define PTDG_ADDR_DUTY_UP 3'h3
`define PTDG_ADDR_SHADOW 3'h4
`define PTDG_ADDR_UNIT_CTRL 3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PTDG_TB_PRESC_LSB 0
`define PTDG_TB_PRESC_MSB 1
`define PTDG_TB_RUN_BIT 2
`define PTDG_TB_POST_LSB 3
`define PTDG_TB_POST_MSB 6
`define PTDG_UC_MODE_LSB 0
`define PTDG_UC_MODE_MSB 3
`define PTDG_UC_DUTY_LSB 4
`define PTDG_UC_DUTY_MSB 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PTDG_RST_COUNTER 8'h00
`define PTDG_RST_PERIOD 8'hff
`define PTDG_RST_TB_CTRL 7'h00
`define PTDG_RST_DUTY_UP 8'h00
`define PTDG_RST_UNIT_CTRL 6'h00

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define PTDG_OSC_PER_INSTR 4
`define PTDG_PHASE_LAST 2'h3
`define PTDG_LIM_DIV1 4'h0
`define PTDG_LIM_DIV4 4'h3
`define PTDG_LIM_DIV16 4'hf

`endif

/* File: rtl/ptdg_pkg.sv */
// types shared by the pwm timebase and duty generator
`default_nettype none
package ptdg_pkg;

  typedef enum {
    PTDG_DIV1,
    PTDG_DIV4,
    PTDG_DIV16
  } ptdg_div_t;

  // prescale select decode, upper select bit dominates
  function automatic ptdg_div_t ptdg_decode_div(input logic [1:0] sel);
    ptdg_div_t d;
    if (sel[1]) begin
      d = PTDG_DIV16;
    end else if (sel[0]) begin
      d = PTDG_DIV4;
    end else begin
      d = PTDG_DIV1;
    end
    return d;
  endfunction

endpackage
`default_nettype wire

/* File: rtl/ptdg_tick_if.sv */
// timebase tick bundle between prescaler and generator
`timescale 1ns/1ps
`default_nettype none
interface ptdg_tick_if;
  logic run;
  logic [1:0] presc;
  logic clear;
  logic tick;
  logic step;
  logic [1:0] fine;
  modport gen (input run, input presc, input clear,
               output tick, output step, output fine);
  modport timer (output run, output presc, output clear,
                 input tick, input step, input fine);
endinterface
`default_nettype wire

/* File: rtl/ptdg_prescaler.sv */
// quarter-phase counter and timebase prescaler
`timescale 1ns/1ps
`default_nettype none
`include "ptdg_defines.svh"
module ptdg_prescaler
  import ptdg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // tick bundle
  ptdg_tick_if.gen tb
);

  logic [1:0] phase_ff;
  logic [3:0] pre_ff;
  logic [3:0] lim;
  logic phase_end;
  ptdg_div_t div;

  // ----------------------------------------------------------------
  // prescale decode
  // ----------------------------------------------------------------
  // select decode
  assign div = ptdg_decode_div(tb.presc);
  always_comb begin
    lim = `PTDG_LIM_DIV1;
    if (div == PTDG_DIV4) begin
      lim = `PTDG_LIM_DIV4;
    end else if (div == PTDG_DIV16) begin
      lim = `PTDG_LIM_DIV16;
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  assign phase_end = (phase_ff == `PTDG_PHASE_LAST);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_ff <= 2'h0;
    end else if (tb.clear) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // prescaler cleared on timer writes so the next tick is predictable
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_ff <= 4'h0;
    end else if (tb.clear) begin
      pre_ff <= 4'h0;
    end else if (tb.run && phase_end) begin
      pre_ff <= (pre_ff >= lim) ? 4'h0 : pre_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // tick each four times prescale
  assign tb.tick = tb.run && phase_end && (pre_ff >= lim);

  always_comb begin
    tb.fine = phase_ff;
    tb.step = tb.run;
    if (div == PTDG_DIV4) begin
      tb.fine = pre_ff[1:0];
      tb.step = tb.run && phase_end;
    end else if (div == PTDG_DIV16) begin
      tb.fine = pre_ff[3:2];
      tb.step = tb.run && phase_end && (pre_ff[1:0] == 2'h3);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_TICK_ON_LAST_PHASE: assert property (
    tb.tick |-> phase_ff == `PTDG_PHASE_LAST)
    else $error("tick outside last phase");
  AST_DIV4_SPACING: assert property (
    (tb.tick && div == PTDG_DIV4 && !tb.clear) ##1
    (tb.run && div == PTDG_DIV4 && !tb.clear)[*8] |-> !tb.tick
    ) else $error("divide by four tick too early");
  AST_DIV16_FINE: assert property (
    (tb.presc == 2'h3) |-> tb.fine == pre_ff[3:2])
    else $error("select 11 not decoded as divide by 16");

endmodule
`default_nettype wire

/* File: rtl/ptdg_top.sv */
// pwm timebase, double-buffered duty and output latch
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ptdg_defines.svh"
module ptdg_top
  import ptdg_pkg::*;
#(
  parameter int ADDR_W = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // port direction bit 2, high means input
  input wire logic port_c_direction_i,
  // output pin
  output logic pwm_output_pin_o,
  output logic pwm_output_pin_oe_o,
  // postscaled period event
  output logic period_event_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 3) begin : g_bad_addr
    $error("ADDR_W must be at least 3");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] counter_ff;
  logic [7:0] period_ff;
  logic [6:0] tb_ctrl_ff;
  logic [7:0] duty_up_ff;
  logic [1:0] duty_lo_ff;
  logic [3:0] mode_ff;
  logic [9:0] shadow_ff;
  logic pin_ff;
  logic [3:0] post_cnt_ff;
  logic event_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [2:0] addr3;
  logic sel_counter;
  logic sel_period;
  logic sel_tb_ctrl;
  logic sel_duty_up;
  logic sel_shadow;
  logic sel_unit_ctrl;
  logic pwm_mode;
  logic wrap;
  logic [9:0] duty_new;
  logic [9:0] pos;
  logic [9:0] pos_inc;
  logic duty_hit;
  logic [3:0] post_lim;

  ptdg_tick_if tb ();

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  assign tb.run = tb_ctrl_ff[`PTDG_TB_RUN_BIT];
  assign tb.presc = tb_ctrl_ff[`PTDG_TB_PRESC_MSB:`PTDG_TB_PRESC_LSB];
  assign tb.clear = wr_i && sel_counter;

  ptdg_prescaler u_presc (
    .sys_clk_i (sys_clk_i),
    .arst_n_i (arst_n_i),
    .tb (tb.gen)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign addr3 = addr_i[2:0];
  always_comb begin
    sel_counter = 1'b0;
    sel_period = 1'b0;
    sel_tb_ctrl = 1'b0;
    sel_duty_up = 1'b0;
    sel_shadow = 1'b0;
    sel_unit_ctrl = 1'b0;
    if (addr_i != ADDR_W'(addr3)) begin
      sel_counter = 1'b0;
    end else if (addr3 == `PTDG_ADDR_COUNTER) begin
      sel_counter = 1'b1;
    end else if (addr3 == `PTDG_ADDR_PERIOD) begin
      sel_period = 1'b1;
    end else if (addr3 == `PTDG_ADDR_TB_CTRL) begin
      sel_tb_ctrl = 1'b1;
    end else if (addr3 == `PTDG_ADDR_DUTY_UP) begin
      sel_duty_up = 1'b1;
    end else if (addr3 == `PTDG_ADDR_SHADOW) begin
      sel_shadow = 1'b1;
    end else if (addr3 == `PTDG_ADDR_UNIT_CTRL) begin
      sel_unit_ctrl = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // period resets to all ones
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      period_ff <= `PTDG_RST_PERIOD;
    end else if (wr_i && sel_period) begin
      period_ff <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tb_ctrl_ff <= `PTDG_RST_TB_CTRL;
    end else if (wr_i && sel_tb_ctrl) begin
      tb_ctrl_ff <= wdata_i[6:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      duty_up_ff <= `PTDG_RST_DUTY_UP;
    end else if (wr_i && sel_duty_up) begin
      duty_up_ff <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {duty_lo_ff, mode_ff} <= `PTDG_RST_UNIT_CTRL;
    end else if (wr_i && sel_unit_ctrl) begin
      duty_lo_ff <= wdata_i[`PTDG_UC_DUTY_MSB:`PTDG_UC_DUTY_LSB];
      mode_ff <= wdata_i[`PTDG_UC_MODE_MSB:`PTDG_UC_MODE_LSB];
    end
  end

  assign pwm_mode = (mode_ff[3:2] == 2'h3);

  // ----------------------------------------------------------------
  // timebase counter
  // ----------------------------------------------------------------
  // match is seen on the increment
  assign wrap = tb.tick && (counter_ff == period_ff) && !tb.clear;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      counter_ff <= `PTDG_RST_COUNTER;
    end else if (tb.clear) begin
      counter_ff <= wdata_i;
    end else if (wrap) begin
      counter_ff <= 8'h00;
    end else if (tb.tick) begin
      counter_ff <= counter_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // duty double buffer
  // ----------------------------------------------------------------
  // upper byte then control bits
  assign duty_new = {duty_up_ff, duty_lo_ff};

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shadow_ff <= 10'h000;
    end else if (wrap) begin
      shadow_ff <= duty_new;
    end
  end

  // ----------------------------------------------------------------
  // output latch
  // ----------------------------------------------------------------
  // position is counter with two fine bits
  assign pos = {counter_ff, tb.fine};
  assign pos_inc = pos + 10'h001;
  // duty past the period never hits
  // clear on the edge that enters the duty position, which makes the
  // high time exactly duty fine steps long
  assign duty_hit = tb.step && (pos_inc == shadow_ff);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_ff <= 1'b0;
    end else if (!pwm_mode) begin
      pin_ff <= 1'b0;
    end else if (wrap) begin
      pin_ff <= (duty_new != 10'h000);
    end else if (duty_hit) begin
      pin_ff <= 1'b0;
    end
  end

  assign pwm_output_pin_o = pin_ff;
  // the pin only drives once software made bit 2 an output
  assign pwm_output_pin_oe_o = pwm_mode && !port_c_direction_i;

  // ----------------------------------------------------------------
  // postscaler
  // ----------------------------------------------------------------
  // divides events, not the period
  assign post_lim = tb_ctrl_ff[`PTDG_TB_POST_MSB:`PTDG_TB_POST_LSB];

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      post_cnt_ff <= 4'h0;
    end else if (wr_i && sel_tb_ctrl) begin
      post_cnt_ff <= 4'h0;
    end else if (wrap) begin
      post_cnt_ff <= (post_cnt_ff >= post_lim) ? 4'h0 : post_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      event_ff <= 1'b0;
    end else begin
      event_ff <= wrap && (post_cnt_ff >= post_lim) &&
                  !(wr_i && sel_tb_ctrl);
    end
  end

  assign period_event_o = event_ff;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    if (sel_counter) begin
      nxt_rdata = counter_ff;
    end else if (sel_period) begin
      nxt_rdata = period_ff;
    end else if (sel_tb_ctrl) begin
      nxt_rdata = {1'b0, tb_ctrl_ff};
    end else if (sel_duty_up) begin
      nxt_rdata = duty_up_ff;
    end else if (sel_shadow) begin
      nxt_rdata = shadow_ff[9:2];
    end else if (sel_unit_ctrl) begin
      nxt_rdata = {2'h0, duty_lo_ff, mode_ff};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_ZERO_CTRL_LOW: assert property (
    (wr_i && sel_unit_ctrl && wdata_i == 8'h00) |-> ##2 !pwm_output_pin_o)
    else $error("zero control did not drop latch");
  AST_WRAP_CLEARS_COUNTER: assert property (
    wrap |=> counter_ff == 8'h00)
    else $error("counter not cleared on limit match");
  AST_WRAP_SETS_PIN: assert property (
    (wrap && pwm_mode && duty_new != 10'h000 && !(wr_i && sel_unit_ctrl))
    |=> pwm_output_pin_o)
    else $error("pin not set at period start");
  AST_ZERO_DUTY_LOW: assert property (
    (wrap && duty_new == 10'h000) |=> !pwm_output_pin_o)
    else $error("zero duty set the pin");
  AST_SHADOW_LOAD: assert property (
    wrap |=> shadow_ff == $past(duty_new))
    else $error("shadow missed duty load");
  AST_SHADOW_HOLD: assert property (
    !wrap |=> $stable(shadow_ff))
    else $error("shadow moved without match");
  AST_DUTY_CLEARS: assert property (
    (duty_hit && !wrap && !(wr_i && sel_unit_ctrl)) |=> !pwm_output_pin_o)
    else $error("pin not cleared at duty position");
  AST_LONG_DUTY_HIGH: assert property (
    (pwm_output_pin_o && pwm_mode && !wrap && !(wr_i && sel_unit_ctrl) &&
     !tb.clear && counter_ff <= period_ff &&
     shadow_ff > {period_ff, 2'h3}) |=> pwm_output_pin_o)
    else $error("long duty cleared the pin");
  AST_DIV1_HIGH_TIME: assert property (
    (wrap && pwm_mode && tb.presc == 2'h0 && duty_new == 10'h003 &&
     period_ff > 8'h00) ##1 (pwm_mode && !wr_i)[*3] |->
    ##1 !pwm_output_pin_o)
    else $error("high time differs from duty");
  AST_EVENT_ON_WRAP: assert property (
    period_event_o |-> $past(wrap))
    else $error("period event without match");

  COV_WRAP_SET: cover property (wrap && pwm_mode && duty_new != 10'h000);
  COV_DUTY_CLEAR: cover property (duty_hit && pwm_mode && pin_ff);
  COV_DIV16_WRAP: cover property (wrap && tb.presc[1]);
  COV_EVENT: cover property (period_event_o && post_lim != 4'h0);

endmodule
`default_nettype wire

/* File: tb/ptdg_load_model.sv */
// external load model that times the waveform on the pwm pin
`timescale 1ns/1ps
`default_nettype none
module ptdg_load_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // pin as driven by the block
  input wire logic pin_i,
  input wire logic pin_oe_i,
  // measured waveform
  output logic level_o,
  output int high_o,
  output int period_o,
  output int rises_o
);
  int hi_cnt_ff;
  int per_cnt_ff;
  logic last_ff;

  // pin drives only when enabled
  // an undriven pin sits at the load's pull-down, never at its last value
  assign level_o = pin_oe_i ? pin_i : 1'b0;

  // measures in whole clocks, so sub-cycle glitches would go unseen
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_ff <= 1'b0;
      hi_cnt_ff <= 0;
      per_cnt_ff <= 0;
      high_o <= 0;
      period_o <= 0;
      rises_o <= 0;
    end else begin
      last_ff <= level_o;
      per_cnt_ff <= per_cnt_ff + 1;
      hi_cnt_ff <= level_o ? hi_cnt_ff + 1 : 0;
      if (level_o && !last_ff) begin
        rises_o <= rises_o + 1;
        period_o <= per_cnt_ff;
        per_cnt_ff <= 1;
      end
      if (!level_o && last_ff) begin
        high_o <= hi_cnt_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/ptdg_top_tb.sv */
// self-checking testbench for the pwm timebase and duty generator
`timescale 1ns/1ps
`default_nettype none
`include "ptdg_defines.svh"
module ptdg_top_tb;
  logic sys_clk;
  logic arst_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic dir;
  logic pin;
  logic pin_oe;
  logic evt;
  logic level;
  int high;
  int period;
  int rises;
  int mismatches;
  int checked;
  logic [7:0] d;
  logic [7:0] d2;

  ptdg_top #(.ADDR_W(3)) i_dut (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .port_c_direction_i(dir), .pwm_output_pin_o(pin),
    .pwm_output_pin_oe_o(pin_oe), .period_event_o(evt));

  ptdg_load_model i_load (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .pin_i(pin),
    .pin_oe_i(pin_oe), .level_o(level), .high_o(high),
    .period_o(period), .rises_o(rises));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
      mismatches++;
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
  endtask

  // bounded wait, a hang counts as a mismatch
  task automatic wait_rises(input int n);
    int s;
    int i;
    s = rises;
    for (i = 0; i < 20000 && rises < s + n; i++) @(posedge sys_clk);
    if (rises < s + n) begin
      mismatches++;
      $display("CHECK FAILED rises expected %0d seen %0d", n, rises - s);
      complete_run();
    end
  endtask

  // bounded wait for the next event pulse, seen at a falling edge
  task automatic wait_evt(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (evt !== 1'b1 && n < 20000);
    if (evt !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED event expected 1 seen %0b", evt);
      complete_run();
    end
  endtask

  // samples over 64 cycles that differ from the expected level
  task automatic count_off(input logic e, output int n);
    n = 0;
    repeat (64) begin
      @(negedge sys_clk);
      if (level !== e) n++;
    end
  endtask

  // set-up in the recommended order, timer restarted from zero
  task automatic setup(input logic [7:0] per, input logic [7:0] up,
                       input logic [1:0] lo, input logic [1:0] ps,
                       input logic [3:0] post, input logic [3:0] mode);
    wr_reg(`PTDG_ADDR_UNIT_CTRL, 8'h00);
    wr_reg(`PTDG_ADDR_TB_CTRL, 8'h00);
    wr_reg(`PTDG_ADDR_COUNTER, 8'h00);
    wr_reg(`PTDG_ADDR_PERIOD, per);
    wr_reg(`PTDG_ADDR_DUTY_UP, up);
    wr_reg(`PTDG_ADDR_UNIT_CTRL, {2'h0, lo, 4'h0});
    @(posedge sys_clk);
    dir <= 1'b0;
    wr_reg(`PTDG_ADDR_TB_CTRL, {1'b0, post, 1'b1, ps});
    wr_reg(`PTDG_ADDR_UNIT_CTRL, {2'h0, lo, mode});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    logic [7:0] exp [6];
    int i;
    exp = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    for (i = 0; i < 6; i++) begin
      rd_reg(i[2:0], d);
      chk("reset value", {24'h0, exp[i]}, {24'h0, d});
    end
    rd_reg(3'h6, d);
    chk("unmapped read", 32'h0, {24'h0, d});
    wr_reg(`PTDG_ADDR_SHADOW, 8'hff);
    rd_reg(`PTDG_ADDR_SHADOW, d);
    chk("shadow read only", 32'h0, {24'h0, d});
    wr_reg(`PTDG_ADDR_UNIT_CTRL, 8'hff);
    rd_reg(`PTDG_ADDR_UNIT_CTRL, d);
    chk("unit control bits", 32'h3f, {24'h0, d});
    chk("pin idle", 32'h0, {31'h0, pin});
    $display("test reset done");
  endtask

  task automatic test_count();
    wr_reg(`PTDG_ADDR_TB_CTRL, 8'h04);
    wr_reg(`PTDG_ADDR_COUNTER, 8'h00);
    rd_reg(`PTDG_ADDR_COUNTER, d);
    repeat (38) @(posedge sys_clk);
    rd_reg(`PTDG_ADDR_COUNTER, d2);
    chk("ticks in 40 clocks", 32'ha, {24'h0, d2 - d});
    $display("test count done");
  endtask

  task automatic test_wave(input logic [7:0] per, input logic [7:0] up,
                           input logic [1:0] lo, input logic [1:0] ps,
                           input logic [3:0] post, input logic [3:0] mode);
    int f;
    int n;
    f = (ps == 2'h0) ? 1 : ((ps == 2'h1) ? 4 : 16);
    setup(per, up, lo, ps, post, mode);
    wait_rises(4);
    chk("period clocks", (per + 1) * 4 * f, period);
    chk("high clocks", {up, lo} * f, high);
    wait_evt(n);
    wait_evt(n);
    chk("event spacing", (post + 1) * (per + 1) * 4 * f, n);
    chk("period unchanged", (per + 1) * 4 * f, period);
    $display("test wave done");
  endtask

  task automatic test_level(input logic [7:0] up, input logic e);
    int n;
    setup(8'h01, up, 2'h0, 2'h0, 4'h0, 4'hc);
    repeat (40) @(posedge sys_clk);
    count_off(e, n);
    chk("steady level", 32'h0, n);
    $display("test level done");
  endtask

  task automatic test_buffer();
    setup(8'h01, 8'h00, 2'h3, 2'h0, 4'h0, 4'hc);
    wait_rises(3);
    wr_reg(`PTDG_ADDR_DUTY_UP, 8'h01);
    rd_reg(`PTDG_ADDR_SHADOW, d);
    chk("shadow before wrap", 32'h0, {24'h0, d});
    wait_rises(3);
    rd_reg(`PTDG_ADDR_SHADOW, d);
    chk("shadow after wrap", 32'h1, {24'h0, d});
    chk("new high clocks", 32'h7, high);
    $display("test buffer done");
  endtask

  task automatic test_off();
    int s;
    int n;
    setup(8'h01, 8'h03, 2'h0, 2'h0, 4'h0, 4'hc);
    repeat (40) @(posedge sys_clk);
    dir <= 1'b1;
    @(negedge sys_clk);
    chk("enable with input dir", 32'h0, {31'h0, pin_oe});
    chk("latch under long duty", 32'h1, {31'h0, pin});
    @(posedge sys_clk);
    dir <= 1'b0;
    wait_rises(1);
    wr_reg(`PTDG_ADDR_UNIT_CTRL, 8'h00);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("latch forced low", 32'h0, {31'h0, pin});
    s = rises;
    n = 0;
    repeat (64) begin
      @(negedge sys_clk);
      if (pin !== 1'b0) n++;
    end
    chk("stays low", 32'h0, n + rises - s);
    wr_reg(`PTDG_ADDR_UNIT_CTRL, 8'h08);
    repeat (20) @(negedge sys_clk);
    chk("mode 10 not pwm", 32'h0, {31'h0, pin});
    wr_reg(`PTDG_ADDR_UNIT_CTRL, 8'h04);
    repeat (20) @(negedge sys_clk);
    chk("mode 01 not pwm", 32'h0, {31'h0, pin});
    $display("test off done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    dir = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    test_reset();
    test_count();
    test_wave(8'h01, 8'h00, 2'h3, 2'h0, 4'h0, 4'hc);
    test_wave(8'h02, 8'h01, 2'h1, 2'h1, 4'h3, 4'hf);
    test_wave(8'h01, 8'h01, 2'h2, 2'h2, 4'h1, 4'hd);
    test_wave(8'h01, 8'h01, 2'h2, 2'h3, 4'h0, 4'he);
    test_level(8'h02, 1'b1);
    test_level(8'h00, 1'b0);
    test_buffer();
    test_off();
    complete_run();
  end
endmodule
`default_nettype wire
